// File: hw/bem_pkg.sv
package bem_pkg;

    // ********************************************************************
    // trace word layout
    // ********************************************************************
    localparam int ADDR_W        = 24;
    localparam int DATA_W        = 16;
    localparam int STAT_W        = 16;
    localparam int LS_W          = 16;
    localparam int CNT_W         = 16;
    localparam int NUM_GROUPS    = 4;
    localparam int GRP_W         = 2;

    // logic state lines
    localparam int LS_CACHE_INH  = 6;
    localparam int LS_LOCKED     = 7;
    localparam int LS_AHI_LSB    = 8;

    // status lines
    localparam int ST_SIZE       = 0;
    localparam int ST_READ       = 1;
    localparam int ST_USER_MEM   = 2;
    localparam int ST_FC_LSB     = 4;
    localparam int ST_BUS_ERR    = 8;
    localparam int ST_IPL_LSB    = 9;
    localparam int ST_AUTOVEC    = 13;
    localparam int ST_INT_PEND   = 14;

    // condition select bits of one action clause
    localparam int C_AC1  = 0;
    localparam int C_AC2  = 1;
    localparam int C_DC1  = 2;
    localparam int C_DC2  = 3;
    localparam int C_ST1  = 4;
    localparam int C_ST2  = 5;
    localparam int C_LSC  = 6;
    localparam int C_CL   = 7;
    localparam int NCOND  = 8;

    // counting mode of a group
    localparam logic [1:0] CM_NONE   = 2'h0;
    localparam logic [1:0] CM_COUNT  = 2'h1;
    localparam logic [1:0] CM_TOGGLE = 2'h2;

    localparam logic [GRP_W-1:0] GRP_FIRST = 2'h0;

    // one traced target bus cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STAT_W-1:0] stat;
        logic [LS_W-1:0]   ls;
    } bem_cycle_t;

    // value with don't-care mask (mask bit set = ignore)
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] dont_care_mask;
    } bem_cmp16_t;

    typedef struct packed {
        logic [ADDR_W-1:0] value;
        logic [ADDR_W-1:0] dont_care_mask;
    } bem_cmp24_t;

    // comparator set of one group
    typedef struct packed {
        bem_cmp24_t address_comparator_one;
        bem_cmp24_t address_comparator_two;
        bem_cmp16_t data_comparator_one;
        bem_cmp16_t data_comparator_two;
        bem_cmp16_t status_comparator_one;
        bem_cmp16_t status_comparator_two;
        bem_cmp16_t logic_state_comparator;
        logic [CNT_W-1:0] count_limit;
        logic [1:0]       count_mode;
    } bem_group_cfg_t;

    // one action clause: conditions ANDed, then actions
    typedef struct packed {
        logic             enable;
        logic [NCOND-1:0] cond_sel;
        logic [NCOND-1:0] cond_inv;
        logic             count_action;
        logic             reload_count_action;
        logic             toggle_count_action;
        logic             pulse_action;
        logic             halt_action;
        logic             event_set_switch;
        logic [GRP_W-1:0] switch_target;
    } bem_clause_t;

endpackage : bem_pkg

// File: hw/bus_event_monitor.sv
`timescale 1ns/10ps

// Notes on behaviour
// - 32-bit address: low comparator plus logic-state high
// - mask bits set are ignored in compare
// - cache inhibit seen on logic-state bit 6
// - status bits 4-6 carry function code
// - status bits 9-11 carry interrupt level
// - bits 14,13,8: pending, autovector, bus error
// - bits 2,1,0: user memory, read, byte
// - one shared counter, limit per group
// - run entry loads counter from group 1
// - count decrements; zero makes limit event
// - action only when all conditions hold
// - reload copies named group limit in
// - group switch keeps counter unless reloaded
// - toggle event flips counting state
// - counter value never visible outside
// - new group counting per its mode
// - toggle carried on keeps counting all
// - run start in group 1 per mode
// - pulse output covers qualifying bus cycle
// - consecutive pulses keep output high
// - logic-state 8-15 hold address 24-31
// - run entry always starts group 1
module bem_bus_event_monitor #(
    parameter int NUM_CLAUSES = 8
) (
    // clock and reset
    input  wire logic                   i_mclk,
    input  wire logic                   i_rstn,
    // run control
    input  wire logic                   i_run,
    // traced bus cycle, one strobe per completed cycle
    input  wire logic                   i_cyc_valid,
    input  wire logic                   i_cyc_end,
    input  wire bem_pkg::bem_cycle_t    i_cyc,
    // configuration
    input  wire bem_pkg::bem_group_cfg_t
                                        i_grp_cfg [bem_pkg::NUM_GROUPS],
    input  wire bem_pkg::bem_clause_t
                 i_clause [bem_pkg::NUM_GROUPS][NUM_CLAUSES],
    // results
    output logic                        o_pulse_output,
    output logic                        o_halt,
    output logic                        o_limit_reached,
    output logic [bem_pkg::GRP_W-1:0]   o_group
);

    // refused at elaboration: clause merge loop serves 1..64 clauses
    if (NUM_CLAUSES < 1 || NUM_CLAUSES > 64) begin : g_bad_clauses
        $error("NUM_CLAUSES out of range");
    end

    // ********************************************************************
    // state
    // ********************************************************************
    typedef enum logic [1:0] {
        BEM_IDLE = 2'b01,
        BEM_RUN  = 2'b10
    } bem_state_t;

    bem_state_t                     state_r;
    logic [bem_pkg::CNT_W-1:0]      counter_r;
    logic [bem_pkg::CNT_W-1:0]      counter_nxt;
    logic                           cnt_on_r;
    logic                           cnt_on_nxt;
    logic                           count_all_r;
    logic                           count_all_nxt;
    logic [bem_pkg::GRP_W-1:0]      group_r;
    logic [bem_pkg::GRP_W-1:0]      group_nxt;
    logic                           pulse_hold_r;
    logic                           halt_r;
    logic                           run_start;
    logic                           eval;
    logic                           do_count;
    logic [1:0]                     new_mode;

    bem_pkg::bem_group_cfg_t        gcfg;
    logic [bem_pkg::NCOND-1:0]      cond;
    logic [NUM_CLAUSES-1:0]         fire;
    logic                           any_cnt;
    logic                           any_rct;
    logic                           any_toc;
    logic                           any_tgr;
    logic                           any_brk;
    logic                           any_sw;
    logic [bem_pkg::GRP_W-1:0]      sw_grp;
    logic [bem_pkg::GRP_W-1:0]      rct_grp;

    assign run_start = i_run && (state_r == BEM_IDLE);
    // one evaluation per completed target cycle
    assign eval      = i_run && (state_r == BEM_RUN) && i_cyc_valid;
    assign gcfg      = i_grp_cfg[group_r];

    // ********************************************************************
    // comparators
    // ********************************************************************
    function automatic logic m16(input logic [15:0] v,
                                 input bem_pkg::bem_cmp16_t c);
        m16 = ((v ^ c.value) & ~c.dont_care_mask) == 16'h0000;
    endfunction : m16

    function automatic logic m24(input logic [23:0] v,
                                 input bem_pkg::bem_cmp24_t c);
        m24 = ((v ^ c.value) & ~c.dont_care_mask) == 24'h00_0000;
    endfunction : m24

    // status and logic-state words are compared whole, so every field
    // (function code, level, flags, cache inhibit, high address) takes
    // the position it holds on the trace word
    always_comb begin
        cond = '0;
        cond[bem_pkg::C_AC1] = m24(i_cyc.addr,
                                   gcfg.address_comparator_one);
        cond[bem_pkg::C_AC2] = m24(i_cyc.addr,
                                   gcfg.address_comparator_two);
        cond[bem_pkg::C_DC1] = m16(i_cyc.data, gcfg.data_comparator_one);
        cond[bem_pkg::C_DC2] = m16(i_cyc.data, gcfg.data_comparator_two);
        cond[bem_pkg::C_ST1] = m16(i_cyc.stat,
                                   gcfg.status_comparator_one);
        cond[bem_pkg::C_ST2] = m16(i_cyc.stat, gcfg.status_comparator_two);
        cond[bem_pkg::C_LSC] = m16(i_cyc.ls,
                                   gcfg.logic_state_comparator);
        // limit event visible as a condition and on o_limit_reached, never as a value
        cond[bem_pkg::C_CL]  = (counter_r == '0);
    end

    // ********************************************************************
    // clause evaluation
    // ********************************************************************
    // a clause fires only when every selected condition is met
    generate
        for (genvar k = 0; k < NUM_CLAUSES; k++) begin : g_cl
            bem_pkg::bem_clause_t cl;
            assign cl      = i_clause[group_r][k];
            assign fire[k] = cl.enable &&
                ((~cl.cond_sel | (cond ^ cl.cond_inv)) == '1);
        end
    endgenerate

    // merge actions of all clauses that fired; lowest clause names group
    always_comb begin
        bem_pkg::bem_clause_t c;
        c       = '0;
        any_cnt = 1'b0;
        any_rct = 1'b0;
        any_toc = 1'b0;
        any_tgr = 1'b0;
        any_brk = 1'b0;
        any_sw  = 1'b0;
        sw_grp  = group_r;
        rct_grp = group_r;
        for (int k = NUM_CLAUSES - 1; k >= 0; k--) begin
            c = i_clause[group_r][k];
            if (fire[k]) begin
                any_cnt = any_cnt | c.count_action;
                any_toc = any_toc ^ c.toggle_count_action;
                any_tgr = any_tgr | c.pulse_action;
                any_brk = any_brk | c.halt_action;
                if (c.reload_count_action) begin
                    any_rct = 1'b1;
                    // reload names the group switched to, else current
                    rct_grp = c.event_set_switch ? c.switch_target
                                                 : group_r;
                end
                if (c.event_set_switch) begin
                    any_sw = 1'b1;
                    sw_grp = c.switch_target;
                end
            end
        end
    end

    // ********************************************************************
    // shared counter and counting state
    // ********************************************************************
    // counting decision of the active group for this bus cycle; a
    // group with no counting mode never counts the counter down
    always_comb begin
        case (gcfg.count_mode)
            bem_pkg::CM_COUNT:  do_count = eval && any_cnt;
            bem_pkg::CM_TOGGLE: do_count = eval &&
                                           (cnt_on_r || count_all_r);
            default:            do_count = 1'b0;
        endcase
    end

    // reload wins over a count in the same cycle; a group switch
    // leaves the value alone, so the count carries into the new group
    always_comb begin
        counter_nxt = counter_r;
        if (run_start) begin
            counter_nxt = i_grp_cfg[bem_pkg::GRP_FIRST].count_limit;
        end else if (eval && any_rct) begin
            counter_nxt = i_grp_cfg[rct_grp].count_limit;
        end else if (do_count && counter_r != '0) begin
            // saturate at zero: limit stays true until reloaded
            counter_nxt = counter_r - 1'b1;
        end
    end

    // mode of the group that a switch would enter
    assign new_mode = i_grp_cfg[sw_grp].count_mode;

    // toggle state; counting is on while either flag is set, the
    // second only until the first toggle after a switch
    always_comb begin
        cnt_on_nxt    = cnt_on_r;
        count_all_nxt = count_all_r;
        if (run_start) begin
            cnt_on_nxt    = 1'b0;
            count_all_nxt = 1'b0;
        end else if (eval) begin
            if (any_toc) begin
                // after a carried-on switch the first toggle stops it
                cnt_on_nxt    = !(cnt_on_r || count_all_r);
                count_all_nxt = 1'b0;
            end
            if (any_sw) begin
                // toggle-on carried into a toggle group counts all
                count_all_nxt = (new_mode == bem_pkg::CM_TOGGLE) &&
                                (gcfg.count_mode == bem_pkg::CM_TOGGLE) &&
                                (cnt_on_nxt || count_all_nxt);
                cnt_on_nxt    = 1'b0;
            end
        end
    end

    // run entry always restarts in the first group, whatever group
    // the previous run ended in
    always_comb begin
        group_nxt = group_r;
        if (run_start) begin
            group_nxt = bem_pkg::GRP_FIRST;
        end else if (eval && any_sw) begin
            group_nxt = sw_grp;
        end
    end

    // ********************************************************************
    // registers
    // ********************************************************************
    // run control
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_r <= BEM_IDLE;
        end else begin
            state_r <= i_run ? BEM_RUN : BEM_IDLE;
        end
    end

    // shared counter
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            counter_r <= '0;
        end else begin
            counter_r <= counter_nxt;
        end
    end

    // toggle state
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            cnt_on_r    <= 1'b0;
            count_all_r <= 1'b0;
        end else begin
            cnt_on_r    <= cnt_on_nxt;
            count_all_r <= count_all_nxt;
        end
    end

    // active event group
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            group_r <= bem_pkg::GRP_FIRST;
        end else begin
            group_r <= group_nxt;
        end
    end

    // pulse output held until the qualified cycle ends; a following
    // qualified cycle strobed in the clock of that end wins over the release, so no gap appears
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !i_run) begin
            pulse_hold_r <= 1'b0;
        end else if (eval) begin
            pulse_hold_r <= any_tgr;
        end else if (i_cyc_end) begin
            pulse_hold_r <= 1'b0;
        end
    end

    // halt request, sticky until run drops
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || !i_run) begin
            halt_r <= 1'b0;
        end else if (eval && any_brk) begin
            halt_r <= 1'b1;
        end
    end

    // pulse pin from a flop, so it never glitches between
    // back-to-back qualified cycles
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_pulse_output <= 1'b0;
        end else begin
            o_pulse_output <= pulse_hold_r;
        end
    end

    // halt request
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_halt <= 1'b0;
        end else begin
            o_halt <= halt_r;
        end
    end

    // limit event only while running; the count itself stays
    // hidden, only reaching zero is shown
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_limit_reached <= 1'b0;
        end else begin
            o_limit_reached <= (state_r == BEM_RUN) && (counter_r == '0);
        end
    end

    // active group
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_group <= bem_pkg::GRP_FIRST;
        end else begin
            o_group <= group_r;
        end
    end

endmodule : bem_bus_event_monitor

// File: verification/bem_bus_event_monitor_monitor.sv
`timescale 1ns/10ps
// ****
// port checker
// ****
module bem_checker (
    // clock and reset
    input wire logic                      i_mclk,
    input wire logic                      i_rstn,
    // stimulus side
    input wire logic                      i_run,
    input wire logic                      i_cyc_valid,
    input wire logic                      i_cyc_end,
    // results
    input wire logic                      o_pulse_output,
    input wire logic                      o_halt,
    input wire logic                      o_limit_reached,
    input wire logic [bem_pkg::GRP_W-1:0] o_group
);
    // one domain, so clock and disable are stated once
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    // reset has to win over everything, so it is not disabled
    chk_reset_clear: assert property (disable iff (1'b0) !i_rstn |=>
        !o_pulse_output && !o_halt && !o_limit_reached && o_group == 2'h0)
        else $error("outputs not cleared by reset");
    chk_run_group:
    assert property ($rose(i_run) |-> ##[1:2] o_group == bem_pkg::GRP_FIRST)
        else $error("run entry not in first group");
    chk_pulse_cause:
    assert property ($rose(o_pulse_output) |-> $past(i_cyc_valid, 2))
        else $error("pulse rose without a bus cycle");
    chk_pulse_end:
    assert property (i_cyc_end && !i_cyc_valid |=> ##1 !o_pulse_output)
        else $error("pulse outlived its bus cycle");
    chk_pulse_no_dip:
    assert property ($fell(o_pulse_output) |-> $past(i_cyc_end, 2))
        else $error("pulse fell inside a bus cycle");
    chk_idle_halt:
    assert property (!i_run |=> ##1 !o_halt)
        else $error("halt held outside run");
    chk_limit_cause:
    assert property ($rose(o_limit_reached) |-> $past(i_run, 2) && $past(i_run))
        else $error("limit event outside run");
    chk_group_hold:
    assert property (i_run && $past(i_run) && $past(i_run, 2) && !i_cyc_valid
        && !$past(i_cyc_valid) |=> $stable(o_group))
        else $error("group moved without a bus cycle");
endmodule : bem_checker

bind bem_bus_event_monitor bem_checker chk_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_run(i_run),
    .i_cyc_valid(i_cyc_valid), .i_cyc_end(i_cyc_end),
    .o_pulse_output(o_pulse_output), .o_halt(o_halt),
    .o_limit_reached(o_limit_reached), .o_group(o_group));

// File: verification/bem_bus_model.sv
`timescale 1ns/10ps
// ****
// traced target bus
// ****
module bem_bus_model (
    // clock
    input  wire logic           i_mclk,
    // traced bus cycle
    output logic                o_cyc_valid,
    output logic                o_cyc_end,
    output bem_pkg::bem_cycle_t o_cyc
);
    logic pend;

    // idle bus at time zero
    initial begin
        o_cyc_valid = 1'b0;
        o_cyc_end = 1'b0;
        o_cyc = '0;
        pend = 1'b0;
    end

    // a new cycle closes the previous one in the same clock
    task automatic issue(input bem_pkg::bem_cycle_t c, input int n);
        @(posedge i_mclk);
        o_cyc_valid <= 1'b1;
        o_cyc_end <= pend;
        o_cyc <= c;
        pend = 1'b1;
        repeat (n) begin
            @(posedge i_mclk);
            o_cyc_valid <= 1'b0;
            o_cyc_end <= 1'b0;
            o_cyc <= ~c; // released lines must not look valid
        end
    endtask : issue

    // close the open cycle with a one-clock end strobe
    task automatic finish();
        @(posedge i_mclk);
        o_cyc_end <= pend;
        pend = 1'b0;
        @(posedge i_mclk);
        o_cyc_end <= 1'b0;
    endtask : finish
endmodule : bem_bus_model

// File: verification/bem_bus_event_monitor_tb_top.sv
`timescale 1ns/10ps
// ****
// bench
// ****
module bem_bus_event_monitor_tb_top;
    logic                    i_mclk;
    logic                    i_rstn;
    logic                    i_run;
    wire logic               i_cyc_valid;
    wire logic               i_cyc_end;
    bem_pkg::bem_cycle_t     i_cyc;
    bem_pkg::bem_group_cfg_t cfg [bem_pkg::NUM_GROUPS];
    bem_pkg::bem_clause_t    cl [bem_pkg::NUM_GROUPS][2];
    logic                    o_pulse_output;
    logic                    o_halt;
    logic                    o_limit_reached;
    logic [1:0]              o_group;
    int                      mismatches;
    int                      checked;
    // action codes: count, reload, toggle, pulse, halt
    localparam logic [4:0] A_CNT = 5'h10, A_TOG = 5'h04;
    localparam logic [4:0] A_PUL = 5'h02, A_HLT = 5'h01;
    logic [15:0] flags [6] = '{16'h4000, 16'h2000, 16'h0100,
                               16'h0004, 16'h0002, 16'h0001};

    bem_bus_model bus (.i_mclk(i_mclk), .o_cyc_valid(i_cyc_valid),
        .o_cyc_end(i_cyc_end), .o_cyc(i_cyc));
    bem_bus_event_monitor #(.NUM_CLAUSES(2)) uut (.i_mclk(i_mclk),
        .i_rstn(i_rstn), .i_run(i_run), .i_cyc_valid(i_cyc_valid),
        .i_cyc_end(i_cyc_end), .i_cyc(i_cyc), .i_grp_cfg(cfg),
        .i_clause(cl), .o_pulse_output(o_pulse_output), .o_halt(o_halt),
        .o_limit_reached(o_limit_reached), .o_group(o_group));

    function automatic bem_pkg::bem_clause_t cls(input logic [7:0] s,
        input logic [4:0] a, input logic sw, input logic [1:0] t);
        return {1'b1, s, 8'h00, a, sw, t};
    endfunction : cls

    task automatic chk(input logic got, input logic exp, input string m);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk

    // all comparators don't care, clauses off, run dropped
    task automatic clear_cfg();
        bem_pkg::bem_group_cfg_t d;
        d = '1;
        d.count_mode = bem_pkg::CM_NONE;
        @(posedge i_mclk);
        i_run <= 1'b0;
        for (int g = 0; g < 4; g++) begin
            cfg[g] <= d;
            cl[g] <= '{25'h0, 25'h0};
        end
    endtask : clear_cfg

    task automatic start_run();
        @(posedge i_mclk);
        i_run <= 1'b1;
        repeat (2) @(posedge i_mclk);
    endtask : start_run

    // one cycle held long enough for the pulse to settle
    task automatic probe(input logic [23:0] a, input logic [15:0] s,
        input logic [15:0] l, input logic exp);
        bus.issue({a, 16'h0, s, l}, 4);
        chk(o_pulse_output, exp, "pulse level");
        bus.finish();
        repeat (3) @(posedge i_mclk);
        chk(o_pulse_output, 1'b0, "pulse stuck");
    endtask : probe

    task automatic t_address();
        clear_cfg();
        cfg[0].address_comparator_one <= {24'h34_5678, 24'h00_0000};
        cfg[0].logic_state_comparator <= {16'h1200, 16'h00FF};
        cl[0][0] <= cls(8'h41, A_PUL, 1'b0, 2'h0);
        start_run();
        probe(24'h34_5678, 16'h0000, 16'h12C3, 1'b1);
        probe(24'h34_5678, 16'h0000, 16'h13C3, 1'b0);
        probe(24'h34_5679, 16'h0000, 16'h12C3, 1'b0);
        clear_cfg();
        cfg[0].logic_state_comparator <= {16'h0040, 16'hFFBF};
        cl[0][0] <= cls(8'h40, A_PUL, 1'b0, 2'h0);
        start_run();
        probe(24'h00_0000, 16'h0000, 16'h00C0, 1'b1);
        probe(24'h00_0000, 16'h0000, 16'h00BF, 1'b0);
        $display("test address done");
    endtask : t_address

    // every function code, priority level and flag, hit and miss
    task automatic t_status();
        logic [15:0] v, m;
        for (int k = 0; k < 22; k++) begin
            if (k < 8) begin
                v = 16'(k) << 4;
                m = 16'hFF8F;
            end else if (k < 16) begin
                v = 16'(k - 8) << 9;
                m = 16'hF1FF;
            end else begin
                v = flags[k - 16];
                m = ~v;
            end
            clear_cfg();
            cfg[0].status_comparator_one <= {v, m};
            cl[0][0] <= cls(8'h10, A_PUL, 1'b0, 2'h0);
            start_run();
            probe(24'h0, v | (m & 16'h8008), 16'h0, 1'b1);
            probe(24'h0, v ^ ~m, 16'h0, 1'b0);
        end
        $display("test status done");
    endtask : t_status

    // counter carried or reloaded across a group switch
    task automatic t_count(input logic rl);
        clear_cfg();
        cfg[0].count_limit <= 16'h0002;
        cfg[0].count_mode <= bem_pkg::CM_COUNT;
        cfg[1].count_limit <= 16'h0005;
        cfg[1].count_mode <= bem_pkg::CM_COUNT;
        cl[0][0] <= cls(8'h00, A_CNT | {1'b0, rl, 3'h0}, 1'b1, 2'h1);
        cl[1][0] <= cls(8'h00, A_CNT, 1'b0, 2'h0);
        cl[1][1] <= cls(8'h80, A_HLT, 1'b0, 2'h0);
        start_run();
        chk(o_limit_reached, 1'b0, "limit at start");
        probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_group === 2'h1, 1'b1, "no switch");
        chk(o_limit_reached, 1'b0, "early limit");
        probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_limit_reached, !rl, "limit after switch");
        probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_halt, !rl, "halt on limit");
        @(posedge i_mclk);
        i_run <= 1'b0;
        repeat (3) @(posedge i_mclk);
        chk(o_halt, 1'b0, "halt after run");
        $display("test count done");
    endtask : t_count

    // toggle once counts on, toggle twice counts off again
    task automatic t_toggle(input logic twice);
        clear_cfg();
        cfg[0].count_limit <= 16'h0003;
        cfg[0].count_mode <= bem_pkg::CM_TOGGLE;
        cfg[0].address_comparator_one <= {24'h00_0100, 24'h00_0000};
        cl[0][0] <= cls(8'h01, A_TOG, 1'b0, 2'h0);
        start_run();
        repeat (2) probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_limit_reached, 1'b0, "counted before toggle");
        probe(24'h100, 16'h0, 16'h0, 1'b0);
        if (twice) probe(24'h100, 16'h0, 16'h0, 1'b0);
        repeat (3) probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_limit_reached, !twice, "toggle state");
        $display("test toggle done");
    endtask : t_toggle

    // toggle-on carried into a toggle group counts every cycle
    task automatic t_carry();
        clear_cfg();
        cfg[0].count_limit <= 16'h0003;
        cfg[0].count_mode <= bem_pkg::CM_TOGGLE;
        cfg[1].count_mode <= bem_pkg::CM_TOGGLE;
        cl[0][0] <= cls(8'h00, A_TOG, 1'b1, 2'h1);
        start_run();
        repeat (3) probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_limit_reached, 1'b0, "carried count early");
        probe(24'h0, 16'h0, 16'h0, 1'b0);
        chk(o_limit_reached, 1'b1, "carried count lost");
        $display("test carry done");
    endtask : t_carry

    // back-to-back pulse cycles, then reset in mid-cycle
    task automatic t_consec();
        clear_cfg();
        cl[0][0] <= cls(8'h00, A_PUL, 1'b0, 2'h0);
        start_run();
        for (int k = 0; k < 4; k++) begin
            bus.issue('0, 1);
            if (k > 1) chk(o_pulse_output, 1'b1, "pulse dipped");
        end
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        // three edges, so the pulse drop lands while reset still holds
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
        chk(o_pulse_output, 1'b0, "pulse kept in reset");
        bus.finish();
        $display("test consecutive done");
    endtask : t_consec

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim

    // 50 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end

    // watchdog, well above the expected run length
    initial begin
        repeat (20000) @(posedge i_mclk);
        mismatches++;
        end_sim();
    end

    initial begin
        i_rstn = 1'b0;
        i_run = 1'b0;
        mismatches = 0;
        checked = 0;
        clear_cfg();
        repeat (9) @(posedge i_mclk);
        i_rstn <= 1'b1;
        t_address();
        t_status();
        t_count(1'b0);
        t_count(1'b1);
        t_toggle(1'b0);
        t_toggle(1'b1);
        t_carry();
        t_consec();
        end_sim();
    end
endmodule : bem_bus_event_monitor_tb_top
